// ===== src/presettable_data_register.sv
// Functional notes
// - enable high, preload low: the input word is captured on the edge.
// - preset high forces the preset constant whatever clock or enable do.
// - preset acts on its level and is active high.
// - preload and enable high: preload constant taken on the next edge.
// - preload wins over the input word on the same enabled edge.
// - enable low: contents hold, input word and preload ignored.
// - enable low does not block the preset.
// - without an enable input the register acts as if enabled.
// - loading is on the rising edge; invert the clock for falling.
// - the output word always shows the contents, no read strobe.
// - power-on contents are the preset constant, zero by default.
// - the preload constant exists with the preload control only.
// - latch style: clock is a gate, enable a gate enable.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "presettable_data_register_defs.svh"

module presettable_data_register
  import presettable_data_register_pkg::*;
#(
  parameter int unsigned WIDTH = `DREG_WIDTH_DEF,
  parameter logic [WIDTH-1:0] ASYNC_VAL = WIDTH'(`DREG_ASYNC_VAL_DEF),
  parameter logic [WIDTH-1:0] SYNC_VAL = WIDTH'(`DREG_SYNC_VAL_DEF),
  parameter bit HAS_CLK_EN = 1'b1,
  parameter bit HAS_SYNC = 1'b1,
  parameter bit LATCH_STYLE = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // user side, same clock as the register
  // driven by logic on this clock, so they are not resynchronised
  input wire logic [WIDTH-1:0] data_in,
  input wire logic clk_en_in,
  input wire logic sync_ctrl_in,
  input wire logic async_ctrl_in,
  output logic [WIDTH-1:0] q_out,
  // ahb-lite slave
  // single slave: hready_in is this slave's own hreadyout looped back
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out
);

  // software-held state
  // evt keeps the sticky flags, while the strobes live one cycle only
  logic src_sw;
  logic sw_preset;
  logic [WIDTH-1:0] sw_data;
  logic stb_load;
  logic stb_preload;
  event_type evt;

  // bus phase tracking
  // wr_data_phase marks the cycle in which hwdata belongs to a write
  wr_phase_type wr_phase;
  logic rd_take;
  logic wr_take;
  logic wr_data_phase;

  // preset level resynchronised for the status bit and the preset event flag only
  // only the second flop of the pair may be read by other logic
  logic preset_meta;
  logic preset_seen;

  // core hookup
  core_ctl_type core_ctl;
  logic [WIDTH-1:0] core_d;
  logic ce_eff;
  logic sync_eff;
  event_type next_evt_set;
  event_type evt_clr;
  logic [31:0] next_rdata;

  // zero-extend a data word to the bus width
  // widths below the bus leave the upper bits at zero on every read
  function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
    logic [31:0] r;
    r = `AHB_DATA_RST;
    r[WIDTH-1:0] = v;
    return r;
  endfunction

  // ------------------------------------------------------------------
  // bus address phase decode; only whole-word transfers act
  // narrower sizes are ignored, not refused: the answer is still OKAY,
  // so a byte access reads zero and writes nothing
  assign rd_take = hsel_in && hready_in && htrans_in[`AHB_TRANS_ACTIVE_BIT]
                   && !hwrite_in && (hsize_in == `AHB_SIZE_WORD);
  assign wr_take = hsel_in && hready_in && htrans_in[`AHB_TRANS_ACTIVE_BIT]
                   && hwrite_in && (hsize_in == `AHB_SIZE_WORD);
  // write data is on hwdata during the cycle after the address phase
  assign wr_data_phase = wr_phase.valid;

  // remember the write address for the data phase
  // a read is served from the address phase itself, so only the write
  // needs its address carried over
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_phase.valid <= 1'b0;
      wr_phase.addr <= `AHB_DATA_RST;
    end else begin
      wr_phase.valid <= wr_take;
      wr_phase.addr <= wr_take ? haddr_in : wr_phase.addr;
    end
  end

  // zero wait states and OKAY always; both stand from reset on
  // registering them costs little and keeps every bus output a flop
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= `AHB_RESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= `AHB_RESP_OKAY;
    end
  end

  // ------------------------------------------------------------------
  // control register: input source select and software preset level
  // the software preset is a level like the pin, so software can park
  // the register at its preset constant for as long as it needs
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_sw <= `DREG_CTRL_SRC_SW_RST;
      sw_preset <= `DREG_CTRL_PRESET_RST;
    end else if (wr_data_phase && wr_phase.addr == `DREG_OFF_CTRL) begin
      src_sw <= hwdata_in[`DREG_CTRL_SRC_SW];
      sw_preset <= hwdata_in[`DREG_CTRL_PRESET];
    end
  end

  // software data word
  // only the low WIDTH bits are kept; upper write bits are dropped
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_data <= WIDTH'(`AHB_DATA_RST);
    end else if (wr_data_phase && wr_phase.addr == `DREG_OFF_DIN) begin
      sw_data <= hwdata_in[WIDTH-1:0];
    end
  end

  // strobes last one cycle so a single write gives a single edge of
  // enable; writing both bits at once is a preload, as on the pins
  // the strobe lands one edge after the data phase, so the core sees it
  // as an ordinary enabled edge and needs no path of its own
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stb_load <= 1'b0;
      stb_preload <= 1'b0;
    end else begin
      stb_load <= wr_data_phase && wr_phase.addr == `DREG_OFF_STROBE
                  && hwdata_in[`DREG_STB_LOAD];
      stb_preload <= wr_data_phase && wr_phase.addr == `DREG_OFF_STROBE
                     && hwdata_in[`DREG_STB_PRELOAD];
    end
  end

  // ------------------------------------------------------------------
  // core input selection: user pins, or software strobes and data
  // the select is a flop on this clock, so a change of source never
  // hands the core half of each side; the preset is the one control
  // that is never switched away
  always_comb begin
    core_ctl.clk_en = src_sw ? (stb_load | stb_preload) : clk_en_in;
    core_ctl.sync_ctrl = src_sw ? stb_preload : sync_ctrl_in;
    // either source may hold the register at its preset constant
    core_ctl.async_ctrl = async_ctrl_in | sw_preset;
    core_d = src_sw ? sw_data : data_in;
  end

  // the storage itself; q_out is its flop or latch output with no stage after
  // kept apart so the latch and flop styles share one wrapper, and the
  // bus side never reaches into it
  data_reg_core #(
    .WIDTH(WIDTH),
    .ASYNC_VAL(ASYNC_VAL),
    .SYNC_VAL(SYNC_VAL),
    .HAS_CLK_EN(HAS_CLK_EN),
    .HAS_SYNC(HAS_SYNC),
    .LATCH_STYLE(LATCH_STYLE)
  ) u_core (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ctl_in(core_ctl),
    .d_in(core_d),
    .q_out(q_out)
  );

  // ------------------------------------------------------------------
  // preset seen by software through two flops, since it is async
  // the preset may change between edges; this pair keeps a metastable
  // sample away from the status bit and the event flag, and nothing
  // but the second flop reads the first
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      preset_meta <= 1'b0;
      preset_seen <= 1'b0;
    end else begin
      preset_meta <= core_ctl.async_ctrl;
      preset_seen <= preset_meta;
    end
  end

  // what the core does at this edge, mirrored for the event flags
  // these must track the core's own fallbacks, or the flags would
  // report edges that the core never acted on
  assign ce_eff = HAS_CLK_EN ? core_ctl.clk_en : 1'b1;
  assign sync_eff = HAS_SYNC ? core_ctl.sync_ctrl : 1'b0;

  always_comb begin
    // the preset flag follows the synchronised level, so it trails the
    // pin by three edges; a preset shorter than a clock may go unseen
    next_evt_set.preset = preset_seen;
    // an edge during preset changes nothing, so it is not an event
    next_evt_set.preload = ce_eff && sync_eff && !core_ctl.async_ctrl;
    next_evt_set.load = ce_eff && !sync_eff && !core_ctl.async_ctrl;
    evt_clr.preset = 1'b0;
    evt_clr.preload = 1'b0;
    evt_clr.load = 1'b0;
    if (wr_data_phase && wr_phase.addr == `DREG_OFF_EVENT) begin
      evt_clr.preset = hwdata_in[`DREG_EVT_PRESET];
      evt_clr.preload = hwdata_in[`DREG_EVT_PRELOAD];
      evt_clr.load = hwdata_in[`DREG_EVT_LOAD];
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  // software that clears in the cycle of a new event sees the flag stay
  // set, so no event is lost between the read and the clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      evt <= `DREG_EVT_RST;
    end else begin
      evt <= (evt & ~evt_clr) | next_evt_set;
    end
  end

  // ------------------------------------------------------------------
  // read mux; unmapped offsets read zero
  // the decode compares the whole address, so aliases above the map
  // read zero as well
  always_comb begin
    next_rdata = `AHB_DATA_RST;
    case (haddr_in)
      `DREG_OFF_CTRL: begin
        next_rdata[`DREG_CTRL_SRC_SW] = src_sw;
        next_rdata[`DREG_CTRL_PRESET] = sw_preset;
      end
      `DREG_OFF_DIN: begin
        next_rdata = widen(sw_data);
      end
      `DREG_OFF_QOUT: begin
        next_rdata = widen(q_out);
      end
      `DREG_OFF_ASYNC: begin
        next_rdata = widen(ASYNC_VAL);
      end
      `DREG_OFF_SYNC: begin
        // an absent preload control has no constant to show
        next_rdata = HAS_SYNC ? widen(SYNC_VAL) : `AHB_DATA_RST;
      end
      `DREG_OFF_STATUS: begin
        next_rdata[`DREG_STS_PRESET_ACT] = preset_seen;
        next_rdata[`DREG_STS_HAS_CE] = HAS_CLK_EN;
        next_rdata[`DREG_STS_HAS_SYNC] = HAS_SYNC;
        next_rdata[`DREG_STS_LATCH] = LATCH_STYLE;
      end
      `DREG_OFF_EVENT: begin
        next_rdata[`DREG_EVT_PRESET] = evt.preset;
        next_rdata[`DREG_EVT_PRELOAD] = evt.preload;
        next_rdata[`DREG_EVT_LOAD] = evt.load;
      end
      default: begin
        next_rdata = `AHB_DATA_RST;
      end
    endcase
  end

  // read data is sampled at the address phase and stands one cycle,
  // which keeps hrdata a plain flop at the cost of showing the value
  // from before a write that completes on that same edge
  // hrdata returns to zero outside a read data phase, so a stale word
  // is never mistaken for an answer
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= `AHB_DATA_RST;
    end else if (rd_take) begin
      hrdata_out <= next_rdata;
    end else begin
      hrdata_out <= `AHB_DATA_RST;
    end
  end

endmodule

// ===== src/presettable_data_register_defs.svh
`ifndef PRESETTABLE_DATA_REGISTER_DEFS_SVH
`define PRESETTABLE_DATA_REGISTER_DEFS_SVH

// bus width, default register word width and default constants
`define DREG_BUS_W 32
`define DREG_WIDTH_DEF 16
`define DREG_ASYNC_VAL_DEF 32'h0000_0000
`define DREG_SYNC_VAL_DEF 32'h0000_0000

// byte offsets of the software registers
`define DREG_OFF_CTRL 32'h0000_0000
`define DREG_OFF_STROBE 32'h0000_0004
`define DREG_OFF_DIN 32'h0000_0008
`define DREG_OFF_QOUT 32'h0000_000C
`define DREG_OFF_ASYNC 32'h0000_0010
`define DREG_OFF_SYNC 32'h0000_0014
`define DREG_OFF_STATUS 32'h0000_0018
`define DREG_OFF_EVENT 32'h0000_001C

// control register fields and reset values
`define DREG_CTRL_SRC_SW 0
`define DREG_CTRL_PRESET 1
`define DREG_CTRL_SRC_SW_RST 1'h0
`define DREG_CTRL_PRESET_RST 1'h0

// strobe register fields
`define DREG_STB_LOAD 0
`define DREG_STB_PRELOAD 1

// status register fields
`define DREG_STS_PRESET_ACT 0
`define DREG_STS_HAS_CE 1
`define DREG_STS_HAS_SYNC 2
`define DREG_STS_LATCH 3

// sticky event register fields
`define DREG_EVT_PRESET 0
`define DREG_EVT_PRELOAD 1
`define DREG_EVT_LOAD 2
`define DREG_EVT_W 3
`define DREG_EVT_RST 3'h0

// bus encodings
`define AHB_TRANS_ACTIVE_BIT 1
`define AHB_SIZE_WORD 3'h2
`define AHB_RESP_OKAY 1'h0
`define AHB_DATA_RST 32'h0000_0000

`endif

// ===== src/presettable_data_register_pkg.sv
package presettable_data_register_pkg;

  // controls that steer the storage core
  typedef struct packed {
    logic clk_en;
    logic sync_ctrl;
    logic async_ctrl;
  } core_ctl_type;

  // address phase held over into the data phase
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } wr_phase_type;

  // sticky events
  typedef struct packed {
    logic load;
    logic preload;
    logic preset;
  } event_type;

endpackage

// ===== src/data_reg_core.sv
`timescale 1ns/10ps
`include "presettable_data_register_defs.svh"

module data_reg_core
  import presettable_data_register_pkg::*;
#(
  parameter int unsigned WIDTH = `DREG_WIDTH_DEF,
  parameter logic [WIDTH-1:0] ASYNC_VAL = WIDTH'(`DREG_ASYNC_VAL_DEF),
  parameter logic [WIDTH-1:0] SYNC_VAL = WIDTH'(`DREG_SYNC_VAL_DEF),
  parameter bit HAS_CLK_EN = 1'b1,
  parameter bit HAS_SYNC = 1'b1,
  parameter bit LATCH_STYLE = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire core_ctl_type ctl_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic ce_eff;
  logic sync_eff;
  logic [WIDTH-1:0] next_q;

  // absent controls fall back to always-enabled and never-preload
  assign ce_eff = HAS_CLK_EN ? ctl_in.clk_en : 1'b1;
  assign sync_eff = HAS_SYNC ? ctl_in.sync_ctrl : 1'b0;
  // preload beats the input word on the same edge
  assign next_q = sync_eff ? SYNC_VAL : d_in;

  generate
    if (LATCH_STYLE) begin : g_latch
      // clock acts as gate, clock enable as gate enable
      always_latch begin
        if (!rst_n_in || ctl_in.async_ctrl) begin
          q_out <= ASYNC_VAL;
        end else if (clk_in && ce_eff) begin
          q_out <= next_q;
        end
      end
    end else begin : g_flop
      // preset is a level on the async set path, so it overrides
      // the edge and the enable for as long as it is high
      always_ff @(posedge clk_in or negedge rst_n_in
                  or posedge ctl_in.async_ctrl) begin
        if (!rst_n_in) begin
          q_out <= ASYNC_VAL;
        end else if (ctl_in.async_ctrl) begin
          q_out <= ASYNC_VAL;
        end else if (ce_eff) begin
          q_out <= next_q;
        end
        // enable low: contents hold across the edge
      end
    end
  endgenerate

endmodule

// ===== tb/dreg_checker.sv
`timescale 1ns/10ps
module dreg_checker #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] ASYNC_VAL = '0,
  parameter logic [WIDTH-1:0] SYNC_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic clk_en_in,
  input wire logic sync_ctrl_in,
  input wire logic async_ctrl_in,
  input wire logic [WIDTH-1:0] q_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out
);
  logic [WIDTH-1:0] q_fall;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // mid-cycle snapshot; a change before the next rising edge is a fault unless preset is high at that edge
  always_ff @(negedge clk_sys_in) begin
    q_fall <= q_out;
  end

  sequence s_quiet;
    !async_ctrl_in;
  endsequence
  sequence s_load;
    clk_en_in && !sync_ctrl_in && !async_ctrl_in;
  endsequence
  sequence s_pre;
    clk_en_in && sync_ctrl_in && !async_ctrl_in;
  endsequence

  AST_LOAD: assert property (s_load ##1 s_quiet |->
    q_out == $past(data_in)) else $error("input word not captured");
  AST_PRELOAD: assert property (s_pre ##1 s_quiet |->
    q_out == SYNC_VAL) else $error("preload constant not taken");
  AST_HOLD: assert property ((!clk_en_in && !async_ctrl_in) ##1 s_quiet |->
    $stable(q_out)) else $error("contents moved with enable low");
  AST_PRESET_HOLD: assert property (async_ctrl_in [*2] |->
    q_out == ASYNC_VAL) else $error("preset value not held");
  AST_PRESET_RISE: assert property ($rose(async_ctrl_in) |->
    q_out == ASYNC_VAL) else $error("preset level not applied");
  AST_PRESET_NOCE: assert property (async_ctrl_in && !clk_en_in |->
    q_out == ASYNC_VAL) else $error("preset blocked by enable");
  AST_POWERON: assert property ($rose(rst_n_in) |->
    q_out == ASYNC_VAL) else $error("wrong contents out of reset");
  AST_RISE_ONLY: assert property (s_quiet |->
    q_out == q_fall) else $error("output moved off the rising edge");
  AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave stalled or erred");
endmodule

bind presettable_data_register dreg_checker #(.WIDTH(WIDTH),
  .ASYNC_VAL(ASYNC_VAL), .SYNC_VAL(SYNC_VAL)) i_chk (.clk_sys_in,
  .rst_n_in, .data_in, .clk_en_in, .sync_ctrl_in, .async_ctrl_in,
  .q_out, .hreadyout_out, .hresp_out);

// ===== tb/user_logic_model.sv
`timescale 1ns/10ps
module user_logic_model
  import presettable_data_register_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_in,
  input wire core_ctl_type next_ctl_in,
  input wire logic [WIDTH-1:0] next_data_in,
  output core_ctl_type ctl_out,
  output logic [WIDTH-1:0] data_out
);
  // launch just after the edge; a disabled word is garbage, not held
  always @(posedge clk_in) begin
    ctl_out <= next_ctl_in;
    data_out <= next_ctl_in.clk_en ? next_data_in : ~data_out;
  end
  initial begin
    ctl_out = '0;
    data_out = '0;
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import presettable_data_register_pkg::*;
  localparam int unsigned W = 16;
  localparam logic [W-1:0] AV = 16'hA5C3;
  localparam logic [W-1:0] SV = 16'h3C5A;
  typedef struct packed {
    logic [2:0] ctl;
    logic [W-1:0] d;
    logic [W-1:0] q;
  } row_type;
  typedef struct packed {
    logic w;
    logic [31:0] a;
    logic [31:0] v;
  } bus_row_type;
  // ctl is enable, preload, preset
  row_type rows [8] = '{'{3'h4, 16'h1234, 16'h1234},
    '{3'h0, 16'hFFFF, 16'h1234}, '{3'h2, 16'hFFFF, 16'h1234},
    '{3'h6, 16'h0F0F, SV}, '{3'h4, 16'hFFFF, 16'hFFFF},
    '{3'h1, 16'h5555, AV}, '{3'h7, 16'h5555, AV},
    '{3'h4, 16'h0000, 16'h0000}};
  // writes to a read-only place must leave no trace; an unmapped place reads zero
  // the event flags stay set from the pin rows; the enable is still high
  // at the clear, so the load flag is set again and wins over the clear
  bus_row_type bus_rows [11] = '{'{1'b1, 32'h8, 32'hBEEF},
    '{1'b0, 32'h8, 32'hBEEF}, '{1'b1, 32'hC, 32'hFFFF},
    '{1'b0, 32'hC, 32'h0}, '{1'b0, 32'h10, 32'(AV)},
    '{1'b0, 32'h14, 32'(SV)}, '{1'b0, 32'h18, 32'h6},
    '{1'b0, 32'h40, 32'h0}, '{1'b0, 32'h1C, 32'h7},
    '{1'b1, 32'h1C, 32'h7}, '{1'b0, 32'h1C, 32'h4}};
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  core_ctl_type next_ctl = '0;
  core_ctl_type ctl;
  logic [W-1:0] next_d = '0;
  logic [W-1:0] d;
  logic [W-1:0] q;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hresp;
  int errors = 0;
  int compares = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  user_logic_model #(.WIDTH(W)) i_user (.clk_in(clk_sys_in),
    .next_ctl_in(next_ctl), .next_data_in(next_d), .ctl_out(ctl),
    .data_out(d));

  presettable_data_register #(.WIDTH(W), .ASYNC_VAL(AV),
    .SYNC_VAL(SV)) i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .data_in(d), .clk_en_in(ctl.clk_en), .sync_ctrl_in(ctl.sync_ctrl),
    .async_ctrl_in(ctl.async_ctrl), .q_out(q), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata));

  task automatic check_word(string n, logic [W-1:0] e, logic [W-1:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_bus(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // single word transfer, held until the slave answers
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] wd);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) @(posedge clk_sys_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys_in);
    while (hready !== 1'b1) @(posedge clk_sys_in);
    rd = hrdata;
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run is under eighty cycles; this is over sixty times that
  initial begin
    #500us;
    errors++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk_sys_in);
      next_ctl <= rows[i].ctl;
      next_d <= rows[i].d;
      repeat (2) @(posedge clk_sys_in);
      #1 check_word("q", rows[i].q, q);
      $display("pin row %0d done", i);
    end
    foreach (bus_rows[i]) begin
      ahb(bus_rows[i].w, bus_rows[i].a, bus_rows[i].v);
      if (!bus_rows[i].w) check_bus("rdata", bus_rows[i].v, rd);
      $display("bus row %0d done", i);
    end
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    // enable off, so the contents still show the preset after release
    next_ctl <= '0;
    #1 check_word("q in reset", AV, q);
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 check_word("q after reset", AV, q);
    $display("reset test done");
    close_out();
  end
endmodule
